// [ebp_consts.svh]
// offsets, field positions, reset values and address map of the bus/port A block
`ifndef EBP_CONSTS_SVH
`define EBP_CONSTS_SVH
`define EBP_OFS_PORT_A_DATA 12'h000
`define EBP_OFS_PORT_A_DIR 12'h004
`define EBP_OFS_CTRL 12'h008
`define EBP_OFS_STATUS 12'h00c
`define EBP_CTRL_MODE_LSB 0
`define EBP_CTRL_MODE_MSB 1
`define EBP_CTRL_NARROW_FOLLOW 2
`define EBP_CTRL_EMULATE_PE 3
`define EBP_CTRL_RESET 8'h00
`define EBP_DIR_RESET 8'h00
`define EBP_DATA_RESET 8'h00
`define EBP_CPU_PORT_A_DATA 16'h0000
`define EBP_CPU_PORT_B_DATA 16'h0001
`define EBP_CPU_PORT_A_DIR 16'h0002
`define EBP_CPU_PORT_B_DIR 16'h0003
`define EBP_CPU_PORT_E_DATA 16'h0008
`define EBP_CPU_PORT_E_DIR 16'h0009
`define EBP_REG_SPACE_LAST 16'h03ff
`define EBP_EXP_REG_COUNT 16'h0010
`define EBP_FOLLOW_FIRST 16'h0400
`define EBP_FOLLOW_LAST 16'h07ff
`define EBP_RAM_FIRST 16'h2000
`define EBP_RAM_BYTES 64
`endif

// [ebp_pkg.sv]
// types shared by the bus/port A block
package ebp_pkg;
  typedef enum logic [1:0] {
    EBP_MODE_SINGLE = 2'h0,
    EBP_MODE_EXP_NARROW = 2'h1,
    EBP_MODE_EXP_WIDE = 2'h2,
    EBP_MODE_PERIPH = 2'h3
  } ebp_mode_e;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_DATA = 5'h04,
    ST_DONE = 5'h08,
    ST_SPARE = 5'h10
  } ebp_state_e;

  typedef struct packed {
    logic write;
    logic word;
    logic [15:0] addr;
    logic [15:0] wdata;
  } ebp_req_s;

  typedef struct packed {
    logic lowByteStrobe;
    logic addr0;
    logic readNotWrite;
    logic swap;
  } ebp_enc_s;
endpackage : ebp_pkg

// [ebp_access_enc.sv]
// access-type encoding on strobe, address bit 0 and read/write
`timescale 1ns/1ps
module ebp_access_enc (
  input wire logic addr0,
  input wire logic word,
  input wire logic write,
  input wire logic internalRam,
  output ebp_pkg::ebp_enc_s enc
);
  always_comb
  begin
    enc.readNotWrite = !write;
    enc.addr0 = addr0;
    enc.swap = 1'b0;
    if (word && !addr0)
    begin
      enc.lowByteStrobe = 1'b0;
    end
    else if (word && internalRam)
    begin
      // misaligned word completes in one cycle only inside the ram
      enc.lowByteStrobe = 1'b1;
      enc.swap = 1'b1;
    end
    else
    begin
      // byte: strobe high on even address, low on odd
      enc.lowByteStrobe = !addr0;
    end
  end
endmodule : ebp_access_enc

// [ebp_port_a.sv]
// port A pin driver: bus lanes or general-purpose I/O per pin
`timescale 1ns/1ps
module ebp_port_a (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic busMode,
  input wire logic [7:0] gpioDir,
  input wire logic [7:0] gpioData,
  input wire logic [7:0] busOut,
  input wire logic [7:0] busOe,
  input wire logic [7:0] pinsIn,
  output wire logic [7:0] pinsOut,
  output wire logic [7:0] pinsOe,
  output wire logic [7:0] readVal
);
  genvar i;
  generate
    for (i = 0; i < 8; i++)
    begin : g_pin
      logic out_q;
      logic out_d;
      logic oe_q;
      logic oe_d;
      always_comb
      begin
        out_d = busMode ? busOut[i] : gpioData[i];
        oe_d = busMode ? busOe[i] : gpioDir[i];
      end
      always_ff @(posedge ref_clk or posedge reset)
      begin
        if (reset)
        begin
          out_q <= 1'b0;
          oe_q <= 1'b0;
        end
        else
        begin
          out_q <= out_d;
          oe_q <= oe_d;
        end
      end
      assign pinsOut[i] = out_q;
      assign pinsOe[i] = oe_q;
      // output pins read back the latch, inputs the pin level
      assign readVal[i] = gpioDir[i] ? gpioData[i] : pinsIn[i];
    end
  endgenerate

  a_gpio_dir_follow: assert property (@(posedge ref_clk) disable iff (reset)
    (!busMode) |=> (pinsOe == $past(gpioDir)))
    else $error("port A enable does not follow direction register");
endmodule : ebp_port_a

// [ebp_top.sv]
// external multiplexed bus sequencer, on-chip map trimming and port A registers
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`include "ebp_consts.svh"
module ebp_top (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cpuReqValid,
  input wire ebp_pkg::ebp_req_s cpuReq,
  output logic cpuReqReady,
  output logic cpuRspValid,
  output logic [15:0] cpuRspData,
  input wire logic [7:0] portAPinsIn,
  output wire logic [7:0] portAPinsOut,
  output wire logic [7:0] portAPinsOe,
  input wire logic [7:0] lowBusIn,
  output logic [7:0] lowBusOut,
  output logic lowBusOe,
  output logic lowByteStrobe,
  output logic addr0,
  output logic readNotWrite,
  output logic addrPhase
);
  ebp_pkg::ebp_state_e state_q, state_d;
  ebp_pkg::ebp_req_s req_q, req_d;
  ebp_pkg::ebp_mode_e mode;
  ebp_pkg::ebp_enc_s enc;
  logic [7:0] ctrl_q, ctrl_d, portAData_q, portAData_d, portADir_q, portADir_d;
  logic [15:0] curAddr_q, curAddr_d, rdata_q, rdata_d, rspData_q, rspData_d;
  logic curWord_q, curWord_d, second_q, second_d, half_q, half_d;
  logic narrow_q, narrow_d, ramHit_q, ramHit_d, rspValid_q, rspValid_d;
  logic ready_q, ready_d, pready_q, pready_d, pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic [7:0] lowOut_q, lowOut_d;
  logic lowOe_q, lowOe_d, strobe_q, strobe_d, a0_q, a0_d, rnw_q, rnw_d;
  logic addrPhase_q, addrPhase_d;
  logic [7:0] paBusOut, paBusOe, portARead;
  logic [7:0] ram [`EBP_RAM_BYTES];
  logic take, busMode, portAMapped, reqRam, reqReg, reqExt, reqNarrow, reqSplit;
  logic apbFirst, apbCommit;
  logic [5:0] ramIdx;
  logic [7:0] ramLo, ramHi, curByte, inByte;

  function automatic logic inRange(input logic [15:0] a, input logic [15:0] lo,
                                   input logic [15:0] hi);
    inRange = (a >= lo) && (a <= hi);
  endfunction : inRange

  // registers that the current mode hands over to the external bus
  function automatic logic isRemoved(input logic [15:0] a, input ebp_pkg::ebp_mode_e m,
                                     input logic emulate_port_e_bit);
    logic exp;
    logic portAB;
    exp = (m == ebp_pkg::EBP_MODE_EXP_NARROW) || (m == ebp_pkg::EBP_MODE_EXP_WIDE);
    portAB = (a == `EBP_CPU_PORT_A_DATA) || (a == `EBP_CPU_PORT_A_DIR)
      || (a == `EBP_CPU_PORT_B_DATA) || (a == `EBP_CPU_PORT_B_DIR);
    isRemoved = ((m == ebp_pkg::EBP_MODE_PERIPH) && (a < `EBP_EXP_REG_COUNT))
      || ((exp || (m == ebp_pkg::EBP_MODE_PERIPH)) && portAB)
      || (exp && emulate_port_e_bit && ((a == `EBP_CPU_PORT_E_DATA) || (a == `EBP_CPU_PORT_E_DIR)));
  endfunction : isRemoved

  function automatic logic wrHit(input logic [15:0] a, input logic word,
                                 input logic [15:0] target);
    wrHit = (a == target) || (word && ((a + 16'h0001) == target));
  endfunction : wrHit

  function automatic logic [7:0] wrLane(input logic [15:0] a, input logic word,
                                        input logic [15:0] wd, input logic [15:0] target);
    wrLane = (word && (a == target)) ? wd[15:8] : wd[7:0];
  endfunction : wrLane

  assign mode = ebp_pkg::ebp_mode_e'(ctrl_q[`EBP_CTRL_MODE_MSB:`EBP_CTRL_MODE_LSB]);
  assign busMode = (mode != ebp_pkg::EBP_MODE_SINGLE);
  assign portAMapped = !busMode;
  assign take = cpuReqValid && ready_q;
  assign reqRam = (cpuReq.addr[15:6] == 10'(`EBP_RAM_FIRST >> 6));
  assign reqReg = (cpuReq.addr <= `EBP_REG_SPACE_LAST)
    && !isRemoved(cpuReq.addr, mode, ctrl_q[`EBP_CTRL_EMULATE_PE]);
  assign reqExt = busMode && !reqRam && !reqReg;
  // narrow follow bit only counts in expanded wide mode
  assign reqNarrow = (mode == ebp_pkg::EBP_MODE_EXP_NARROW)
    || ((mode == ebp_pkg::EBP_MODE_EXP_WIDE) && ctrl_q[`EBP_CTRL_NARROW_FOLLOW]
        && inRange(cpuReq.addr, `EBP_FOLLOW_FIRST, `EBP_FOLLOW_LAST));
  // outside the ram a word either fits one aligned wide cycle or splits in two
  assign reqSplit = cpuReq.word && (reqNarrow || cpuReq.addr[0]);
  assign ramIdx = cpuReq.addr[5:0];
  assign ramLo = ram[ramIdx];
  assign ramHi = ram[ramIdx + 6'h01];
  assign apbFirst = psel && penable && !pready_q;
  assign apbCommit = psel && penable && pready_q && pwrite && !pslverr_q;

  ebp_access_enc u_enc (
    .addr0(curAddr_d[0]),
    .word(curWord_d),
    .write(req_d.write),
    .internalRam(ramHit_d),
    .enc(enc)
  );

  ebp_port_a u_port_a (
    .ref_clk(ref_clk),
    .reset(reset),
    .busMode(busMode),
    .gpioDir(portADir_q),
    .gpioData(portAData_q),
    .busOut(paBusOut),
    .busOe(paBusOe),
    .pinsIn(portAPinsIn),
    .pinsOut(portAPinsOut),
    .pinsOe(portAPinsOe),
    .readVal(portARead)
  );

  always_comb
  begin
    state_d = state_q;
    req_d = req_q;
    curAddr_d = curAddr_q;
    curWord_d = curWord_q;
    second_d = second_q;
    half_d = half_q;
    narrow_d = narrow_q;
    ramHit_d = ramHit_q;
    rdata_d = rdata_q;
    ready_d = ready_q;
    rspValid_d = 1'b0;
    rspData_d = rspData_q;
    portAData_d = portAData_q;
    portADir_d = portADir_q;
    ctrl_d = ctrl_q;
    paBusOut = 8'h00;
    paBusOe = 8'h00;
    lowOut_d = 8'h00;
    lowOe_d = 1'b0;
    strobe_d = strobe_q;
    a0_d = a0_q;
    rnw_d = rnw_q;
    addrPhase_d = 1'b0;
    curByte = req_q.word ? (half_q ? req_q.wdata[7:0] : req_q.wdata[15:8]) : req_q.wdata[7:0];
    inByte = (narrow_q || !curAddr_q[0]) ? portAPinsIn : lowBusIn;
    case (state_q)
      ebp_pkg::ST_IDLE:
      begin
        if (take)
        begin
          req_d = cpuReq;
          ready_d = 1'b0;
          curAddr_d = cpuReq.addr;
          ramHit_d = reqRam;
          narrow_d = reqNarrow;
          half_d = 1'b0;
          second_d = reqExt && reqSplit;
          curWord_d = cpuReq.word && !(reqExt && reqSplit);
          state_d = reqExt ? ebp_pkg::ST_ADDR : ebp_pkg::ST_DONE;
          if (reqRam)
          begin
            rdata_d = cpuReq.word ? {ramLo, ramHi} : {8'h00, ramLo};
          end
          else if (reqReg)
          begin
            rdata_d = 16'h0000;
            if (cpuReq.addr == `EBP_CPU_PORT_A_DATA)
            begin
              rdata_d = cpuReq.word ? {portARead, 8'h00} : {8'h00, portARead};
            end
            else if (cpuReq.addr == `EBP_CPU_PORT_A_DIR)
            begin
              rdata_d = cpuReq.word ? {portADir_q, 8'h00} : {8'h00, portADir_q};
            end
            if (cpuReq.write && wrHit(cpuReq.addr, cpuReq.word, `EBP_CPU_PORT_A_DATA))
            begin
              portAData_d = wrLane(cpuReq.addr, cpuReq.word, cpuReq.wdata,
                                   `EBP_CPU_PORT_A_DATA);
            end
            if (cpuReq.write && wrHit(cpuReq.addr, cpuReq.word, `EBP_CPU_PORT_A_DIR))
            begin
              portADir_d = wrLane(cpuReq.addr, cpuReq.word, cpuReq.wdata,
                                  `EBP_CPU_PORT_A_DIR);
            end
          end
          else
          begin
            rdata_d = 16'h0000;
          end
        end
        else
        begin
          ready_d = 1'b1;
        end
      end
      ebp_pkg::ST_ADDR:
      begin
        state_d = ebp_pkg::ST_DATA;
      end
      ebp_pkg::ST_DATA:
      begin
        if (curWord_q)
        begin
          rdata_d = {portAPinsIn, lowBusIn};
        end
        else if (req_q.word)
        begin
          rdata_d = half_q ? {rdata_q[15:8], inByte} : {inByte, rdata_q[7:0]};
        end
        else
        begin
          rdata_d = {8'h00, inByte};
        end
        if (second_q)
        begin
          // second byte of a split word, back to back with the first
          second_d = 1'b0;
          half_d = 1'b1;
          curAddr_d = curAddr_q + 16'h0001;
          state_d = ebp_pkg::ST_ADDR;
        end
        else
        begin
          state_d = ebp_pkg::ST_DONE;
        end
      end
      ebp_pkg::ST_DONE:
      begin
        rspValid_d = 1'b1;
        rspData_d = rdata_q;
        ready_d = 1'b1;
        state_d = ebp_pkg::ST_IDLE;
      end
      default:
      begin
        state_d = ebp_pkg::ST_IDLE;
        ready_d = 1'b1;
      end
    endcase
    if (state_d == ebp_pkg::ST_ADDR)
    begin
      paBusOut = curAddr_d[15:8];
      paBusOe = 8'hff;
      lowOut_d = curAddr_d[7:0];
      lowOe_d = 1'b1;
      addrPhase_d = 1'b1;
      strobe_d = enc.lowByteStrobe;
      a0_d = enc.addr0;
      rnw_d = enc.readNotWrite;
    end
    else if ((state_d == ebp_pkg::ST_DATA) && req_q.write)
    begin
      if (curWord_q)
      begin
        paBusOut = req_q.wdata[15:8];
        paBusOe = 8'hff;
        lowOut_d = req_q.wdata[7:0];
        lowOe_d = 1'b1;
      end
      else if (narrow_q || !curAddr_q[0])
      begin
        paBusOut = curByte;
        paBusOe = 8'hff;
      end
      else
      begin
        lowOut_d = curByte;
        lowOe_d = 1'b1;
      end
    end
    else if ((state_d == ebp_pkg::ST_DONE) && (state_q == ebp_pkg::ST_IDLE)
             && reqRam && busMode)
    begin
      // in the bus modes ram cycles are shown on the pins; misaligned words swap lanes
      strobe_d = enc.lowByteStrobe;
      a0_d = enc.addr0;
      rnw_d = enc.readNotWrite;
      paBusOe = 8'hff;
      lowOe_d = 1'b1;
      paBusOut = enc.swap ? rdata_d[7:0] : rdata_d[15:8];
      lowOut_d = enc.swap ? rdata_d[15:8] : rdata_d[7:0];
      if (cpuReq.write)
      begin
        paBusOut = enc.swap ? cpuReq.wdata[7:0] : cpuReq.wdata[15:8];
        lowOut_d = enc.swap ? cpuReq.wdata[15:8] : cpuReq.wdata[7:0];
      end
    end
    // software bus wins over a cpu write landing in the same cycle
    if (apbCommit)
    begin
      case (paddr)
        `EBP_OFS_PORT_A_DATA: portAData_d = pwdata[7:0];
        `EBP_OFS_PORT_A_DIR: portADir_d = pwdata[7:0];
        `EBP_OFS_CTRL: ctrl_d = {4'h0, pwdata[3:0]};
        default: ctrl_d = ctrl_d;
      endcase
    end
  end

  always_comb
  begin
    pready_d = apbFirst;
    pslverr_d = 1'b0;
    prdata_d = prdata_q;
    if (apbFirst)
    begin
      prdata_d = 32'h00000000;
      case (paddr)
        `EBP_OFS_PORT_A_DATA:
        begin
          prdata_d = {24'h000000, portAMapped ? portARead : 8'h00};
          pslverr_d = !portAMapped;
        end
        `EBP_OFS_PORT_A_DIR:
        begin
          prdata_d = {24'h000000, portAMapped ? portADir_q : 8'h00};
          pslverr_d = !portAMapped;
        end
        `EBP_OFS_CTRL: prdata_d = {24'h000000, ctrl_q};
        `EBP_OFS_STATUS: prdata_d = {24'h000000, strobe_q, a0_q, narrow_q, state_q};
        default: pslverr_d = 1'b1;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (take && reqRam && cpuReq.write)
    begin
      ram[ramIdx] <= cpuReq.word ? cpuReq.wdata[15:8] : cpuReq.wdata[7:0];
      if (cpuReq.word)
      begin
        ram[ramIdx + 6'h01] <= cpuReq.wdata[7:0];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      state_q <= ebp_pkg::ST_IDLE;
      req_q <= '0;
      curAddr_q <= 16'h0000;
      curWord_q <= 1'b0;
      second_q <= 1'b0;
      half_q <= 1'b0;
      narrow_q <= 1'b0;
      ramHit_q <= 1'b0;
      rdata_q <= 16'h0000;
      ready_q <= 1'b0;
      rspValid_q <= 1'b0;
      rspData_q <= 16'h0000;
      portAData_q <= `EBP_DATA_RESET;
      portADir_q <= `EBP_DIR_RESET;
      ctrl_q <= `EBP_CTRL_RESET;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
      lowOut_q <= 8'h00;
      lowOe_q <= 1'b0;
      strobe_q <= 1'b1;
      a0_q <= 1'b0;
      rnw_q <= 1'b1;
      addrPhase_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      req_q <= req_d;
      curAddr_q <= curAddr_d;
      curWord_q <= curWord_d;
      second_q <= second_d;
      half_q <= half_d;
      narrow_q <= narrow_d;
      ramHit_q <= ramHit_d;
      rdata_q <= rdata_d;
      ready_q <= ready_d;
      rspValid_q <= rspValid_d;
      rspData_q <= rspData_d;
      portAData_q <= portAData_d;
      portADir_q <= portADir_d;
      ctrl_q <= ctrl_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
      lowOut_q <= lowOut_d;
      lowOe_q <= lowOe_d;
      strobe_q <= strobe_d;
      a0_q <= a0_d;
      rnw_q <= rnw_d;
      addrPhase_q <= addrPhase_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign cpuReqReady = ready_q;
  assign cpuRspValid = rspValid_q;
  assign cpuRspData = rspData_q;
  assign lowBusOut = lowOut_q;
  assign lowBusOe = lowOe_q;
  assign lowByteStrobe = strobe_q;
  assign addr0 = a0_q;
  assign readNotWrite = rnw_q;
  assign addrPhase = addrPhase_q;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  a_both_high_ram: assert property ((strobe_q && a0_q && $changed({strobe_q, a0_q})) |-> ramHit_q)
    else $error("strobe and a0 both high outside a ram cycle");
  a_byte_enc_pins: assert property ((state_q == ebp_pkg::ST_ADDR && !curWord_q)
    |-> (strobe_q == !curAddr_q[0]) && (a0_q == curAddr_q[0]))
    else $error("byte cycle encoding wrong");
  a_word_even_enc: assert property ((state_q == ebp_pkg::ST_ADDR && curWord_q)
    |-> !strobe_q && !a0_q)
    else $error("even word encoding wrong");
  a_rw_level_dir: assert property ((state_q == ebp_pkg::ST_ADDR)
    |-> (rnw_q == !req_q.write))
    else $error("read/write level wrong");
  a_split_two_bytes: assert property ((state_q == ebp_pkg::ST_DATA && second_q)
    |=> (state_q == ebp_pkg::ST_ADDR) && (curAddr_q == $past(curAddr_q) + 16'h0001)
    ##1 (state_q == ebp_pkg::ST_DATA))
    else $error("split word did not issue its second byte");
  a_narrow_low_quiet: assert property ((state_q == ebp_pkg::ST_DATA && narrow_q)
    |-> !lowOe_q)
    else $error("narrow cycle drove the low data lanes");
  a_addr_hi_pins: assert property ((state_q == ebp_pkg::ST_ADDR)
    |-> (portAPinsOut == curAddr_q[15:8]) && (portAPinsOe == 8'hff))
    else $error("port A does not carry the high address");
  a_port_a_unmapped: assert property ((psel && penable && pready_q
    && (paddr == `EBP_OFS_PORT_A_DATA) && busMode && $stable(ctrl_q)) |-> pslverr_q)
    else $error("port A reached while removed from the map");
  a_odd_ram_swap: assert property ((ramHit_q && strobe_q && a0_q && !rnw_q
    && state_q == ebp_pkg::ST_DONE) |-> (lowOut_q == req_q.wdata[15:8]))
    else $error("misaligned ram write not swapped");
  // encoder must never pair strobe and a0 high for anything but the ram
  a_enc_both_ram: assert property ((enc.lowByteStrobe && enc.addr0) |-> ramHit_d)
    else $error("encoder shows strobe and a0 high outside the ram");
  c_split_word: cover property ((state_q == ebp_pkg::ST_DATA) && second_q);
  c_ram_misaligned: cover property (ramHit_q && strobe_q && a0_q);
  c_apb_write_dir: cover property (apbCommit && (paddr == `EBP_OFS_PORT_A_DIR));
endmodule : ebp_top

// [ebp_ext_mem.sv]
// external memory model facing the multiplexed bus and port A
`timescale 1ns/1ps
module ebp_ext_mem (
  input wire logic ref_clk,
  input wire logic narrow,
  input wire logic [7:0] gpioLevel,
  input wire logic [7:0] portAOut,
  input wire logic [7:0] portAOe,
  input wire logic [7:0] lowOut,
  input wire logic addrPhase,
  input wire logic readNotWrite,
  output logic [7:0] portAIn,
  output logic [7:0] lowIn,
  output logic [7:0] wrHi,
  output logic [7:0] wrLo
);
  logic [15:0] addrQ = '0;
  logic dataQ = 0;
  logic [7:0] lastQ = '0;
  logic [7:0] extA;
  function automatic logic [7:0] mem(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction : mem
  // even byte on port A, odd on low lanes, all on port A when narrow
  assign extA = dataQ && readNotWrite ?
    mem(narrow ? addrQ : {addrQ[15:1], 1'b0}) : gpioLevel;
  assign portAIn = (portAOe & portAOut) | (~portAOe & extA);
  // released low lanes never keep the last value
  assign lowIn = dataQ && readNotWrite ? mem({addrQ[15:1], 1'b1}) : ~lastQ;
  always @(posedge ref_clk)
  begin
    lastQ <= lowIn;
    dataQ <= addrPhase;
    if (addrPhase)
      addrQ <= {portAOut, lowOut};
    if (dataQ && !readNotWrite)
    begin
      wrHi <= portAOut;
      wrLo <= lowOut;
    end
  end
endmodule : ebp_ext_mem

// [test_ebp_top.sv]
// self-checking bench for the bus/port A block
`timescale 1ns/1ps
module test_ebp_top;
  logic ref_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, cpuReqValid = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, cpuReqReady, cpuRspValid, lowBusOe, er, narrow = 0;
  logic lowByteStrobe, addr0, readNotWrite, addrPhase;
  ebp_pkg::ebp_req_s cpuReq = '0;
  logic [15:0] cpuRspData, cd, lanes;
  logic [7:0] pinIn, pinOut, pinOe, lowIn, lowOut, gpioLevel = '0, wrHi, wrLo;
  logic [2:0] enc;
  int err_total = 0, checked = 0, nAp;
  ebp_top i_dut (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpuReqValid(cpuReqValid), .cpuReq(cpuReq),
    .cpuReqReady(cpuReqReady), .cpuRspValid(cpuRspValid), .cpuRspData(cpuRspData),
    .portAPinsIn(pinIn), .portAPinsOut(pinOut), .portAPinsOe(pinOe), .lowBusIn(lowIn),
    .lowBusOut(lowOut), .lowBusOe(lowBusOe), .lowByteStrobe(lowByteStrobe),
    .addr0(addr0), .readNotWrite(readNotWrite), .addrPhase(addrPhase));
  ebp_ext_mem i_mem (.ref_clk(ref_clk), .narrow(narrow), .gpioLevel(gpioLevel),
    .portAOut(pinOut), .portAOe(pinOe), .lowOut(lowOut), .addrPhase(addrPhase),
    .readNotWrite(readNotWrite), .portAIn(pinIn), .lowIn(lowIn), .wrHi(wrHi), .wrLo(wrLo));
  initial
  begin
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic finish_test();
    if (err_total == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, want, seen);
    end
  endtask : check
  // a used-up wait bound counts as a mismatch and ends the run
  task automatic limit(input int n);
    if (n >= 50)
    begin
      err_total++;
      finish_test();
    end
  endtask : limit
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge ref_clk);
      if (pready === 1'b1)
        break;
    end
    limit(i);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic cpu(input logic w, input logic wd, input logic [15:0] a, input logic [15:0] d);
    int i;
    @(posedge ref_clk);
    cpuReq <= '{write: w, word: wd, addr: a, wdata: d};
    cpuReqValid <= 1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge ref_clk);
      if (cpuReqReady === 1'b1)
        break;
    end
    limit(i);
    cpuReqValid <= 0;
    nAp = 0;
    enc = 'x;
    for (i = 0; i < 50 && cpuRspValid !== 1'b1; i++)
    begin
      @(negedge ref_clk);
      // a ram cycle shows its lanes only in the cycle after the take
      if (i == 0)
        lanes = {lowOut, pinOut};
      if (addrPhase === 1'b1 && nAp++ == 0)
        enc = {lowByteStrobe, addr0, readNotWrite};
    end
    limit(i);
    cd = cpuRspData;
  endtask : cpu
  function automatic logic [7:0] eb(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction : eb
  function automatic logic [15:0] ew(input logic wd, input logic [15:0] a);
    return wd ? {eb(a), eb(a + 16'h1)} : {8'h00, eb(a)};
  endfunction : ew
  initial
  begin
    logic [15:0] a, d;
    logic [7:0] dir, dat;
    logic [1:0] b;
    logic split;
    int m;
    void'($urandom(62));
    repeat (6) @(posedge ref_clk);
    reset <= 0;
    apb(0, 12'h004, 0);
    check("dir reset", rd, 0);
    apb(0, 12'h010, 0);
    check("unmapped", er, 1);
    for (int i = 0; i < 8; i++)
    begin
      dir = $urandom;
      dat = $urandom;
      gpioLevel <= $urandom;
      apb(1, 12'h004, {24'h0, dir});
      apb(1, 12'h000, {24'h0, dat});
      apb(0, 12'h000, 0);
      check("gpio read", rd, (dat & dir) | (gpioLevel & ~dir));
      check("pin oe", pinOe, dir);
      check("pin out", pinOut & dir, dat & dir);
    end
    for (m = 1; m < 4; m++)
    begin
      apb(1, 12'h008, m);
      narrow <= m == 1;
      apb(0, 12'h004, 0);
      check("dir unmapped", er, 1);
      apb(0, 12'h000, 0);
      check("data unmapped", er, 1);
      cpu(0, 0, 16'h0000, 0);
      check("port_a_data cycles", nAp, 1);
      check("port_a_data byte", cd, ew(0, 16'h0000));
      cpu(0, 0, 16'h000f, 0);
      if (m == 3)
        check("periph cycles", nAp, 1);
    end
    // narrow, wide, then wide with a narrow register-following space
    for (int i = 0; i < 60; i++)
    begin
      m = i / 20;
      if (i % 20 == 0)
        apb(1, 12'h008, m == 0 ? 1 : m == 1 ? 2 : 6);
      narrow <= m != 1;
      a = m == 2 ? 16'h0400 | 10'($urandom) : {1'b1, 15'($urandom)};
      b = $urandom;
      d = $urandom;
      cpu(b[1], b[0], a, d);
      split = b[0] & (a[0] | m != 1);
      check("cycles", nAp, split ? 2 : 1);
      check("encoding", enc, {(b[0] & ~split) ~^ a[0], a[0], ~b[1]});
      if (!b[1])
        check("read data", cd, ew(b[0], a));
      if (m == 1 && b == 2'b11 && !a[0])
        check("write lanes", {wrHi, wrLo}, d);
      if (m != 1 && b[1])
        check("narrow lane", wrHi, d[7:0]);
    end
    apb(1, 12'h008, 2);
    narrow <= 0;
    cpu(1, 1, 16'h2011, 16'hc3a5);
    check("ram encoding", {lowByteStrobe, addr0, readNotWrite}, 3'b110);
    check("ram lanes", lanes, 16'hc3a5);
    cpu(0, 1, 16'h2011, 0);
    check("ram word", cd, 16'hc3a5);
    cpu(0, 0, 16'h0008, 0);
    check("port e local", nAp, 0);
    apb(1, 12'h008, 10);
    cpu(0, 0, 16'h0008, 0);
    check("port e external", nAp, 1);
    finish_test();
  end
endmodule : test_ebp_top
